// >>> rtl/ictf_framer.sv
// Purpose: builds nested type-length-value content messages from captured packets
// Assumes: caller keeps one message under the memory depth
// Notes:   message is assembled in memory, lengths patched, then streamed out

`timescale 1ns/1ps
`default_nettype none

module ictf_framer (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic meta_valid_i,
   input wire ictf_pkg::ictf_hdr_t meta_i,
   output logic meta_ready_o,
   input wire logic in_valid_i,
   input wire ictf_pkg::ictf_byte_t in_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output ictf_pkg::ictf_out_t out_o,
   input wire logic out_ready_i
);

   // ************************************************************
   // field helpers
   // ************************************************************
   function automatic logic [15:0] field_type(input logic [3:0] f);
      logic [15:0] t;
      case (f)
         ictf_pkg::F_HWRAP: t = ictf_pkg::TYPE_HDR;
         ictf_pkg::F_VER: t = ictf_pkg::TYPE_VER;
         ictf_pkg::F_KIND: t = ictf_pkg::TYPE_KIND;
         ictf_pkg::F_TIME: t = ictf_pkg::TYPE_TIME;
         ictf_pkg::F_DIR: t = ictf_pkg::TYPE_DIR;
         ictf_pkg::F_SEQ: t = ictf_pkg::TYPE_SEQ;
         ictf_pkg::F_CORR: t = ictf_pkg::TYPE_CORR;
         ictf_pkg::F_INTERCEPT_IDENTIFIER_FIELD: t = ictf_pkg::TYPE_INTERCEPT_IDENTIFIER_FIELD;
         default: t = ictf_pkg::TYPE_BODY;
      endcase
      return t;
   endfunction

   function automatic logic field_present(input logic [3:0] f, input ictf_pkg::ictf_hdr_t h);
      logic p;
      case (f)
         ictf_pkg::F_TIME: p = h.has_time;
         ictf_pkg::F_DIR: p = h.has_dir;
         ictf_pkg::F_SEQ: p = h.has_seq;
         ictf_pkg::F_INTERCEPT_IDENTIFIER_FIELD: p = (h.intercept_identifier_field_len != 5'h00) && (h.intercept_identifier_field_len <= ictf_pkg::INTERCEPT_IDENTIFIER_FIELD_MAX);
         default: p = 1'b1;
      endcase
      return p;
   endfunction

   // wrappers report zero here; their value is the nested elements
   function automatic logic [15:0] field_vlen(input logic [3:0] f, input ictf_pkg::ictf_hdr_t h);
      logic [15:0] l;
      case (f)
         ictf_pkg::F_VER: l = ictf_pkg::VER_LEN;
         ictf_pkg::F_KIND: l = ictf_pkg::KIND_LEN;
         ictf_pkg::F_TIME: l = ictf_pkg::TIME_LEN;
         ictf_pkg::F_DIR: l = ictf_pkg::DIR_LEN;
         ictf_pkg::F_SEQ: l = ictf_pkg::SEQ_LEN;
         ictf_pkg::F_CORR: l = h.corr_long ? ictf_pkg::CORR_LONG : ictf_pkg::CORR_SHORT;
         ictf_pkg::F_INTERCEPT_IDENTIFIER_FIELD: l = {11'h000, h.intercept_identifier_field_len};
         default: l = 16'h0000;
      endcase
      return l;
   endfunction

   function automatic logic [15:0] hdr_len(input ictf_pkg::ictf_hdr_t h);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 1; i <= 7; i++) begin
         if (field_present(4'(i), h)) begin
            s = s + ictf_pkg::TL_BYTES + field_vlen(4'(i), h);
         end
      end
      return s;
   endfunction

   function automatic logic [7:0] val_byte(input logic [3:0] f, input ictf_pkg::ictf_hdr_t h,
                                           input logic [4:0] k);
      logic [7:0] v;
      logic [7:0] sh;
      sh = {k, 3'b000};
      case (f)
         ictf_pkg::F_VER: v = 8'(h.version >> sh);
         ictf_pkg::F_KIND: v = h.kind;
         ictf_pkg::F_TIME: v = 8'(h.stamp >> sh);
         ictf_pkg::F_DIR: v = {7'h00, h.dir};
         ictf_pkg::F_SEQ: v = 8'(h.seq >> sh);
         ictf_pkg::F_CORR: v = 8'(h.corr >> sh);
         ictf_pkg::F_INTERCEPT_IDENTIFIER_FIELD: v = 8'(h.intercept_identifier_field >> sh);
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // type and length low octet first, then value
   function automatic logic [7:0] field_byte(input logic [3:0] f, input logic [4:0] b,
                                             input ictf_pkg::ictf_hdr_t h);
      logic [15:0] t;
      logic [15:0] l;
      logic [7:0] v;
      t = field_type(f);
      l = (f == ictf_pkg::F_HWRAP) ? hdr_len(h) : field_vlen(f, h);
      case (b)
         5'h00: v = t[7:0];
         5'h01: v = t[15:8];
         5'h02: v = l[7:0];
         5'h03: v = l[15:8];
         default: v = val_byte(f, h, b - 5'h04);
      endcase
      return v;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   ictf_pkg::ictf_state_t state_q, state_d;
   ictf_pkg::ictf_hdr_t hdr_q, hdr_d;
   ictf_pkg::ictf_out_t out_q, out_d;
   logic [11:0] wp_q, wp_d;
   logic [11:0] rp_q, rp_d;
   logic [11:0] blen_addr_q, blen_addr_d;
   logic [15:0] blen_q, blen_d;
   logic [3:0] f_q, f_d;
   logic [4:0] b_q, b_d;
   logic [2:0] pc_q, pc_d;
   logic meta_ready_q, meta_ready_d;
   logic in_ready_q, in_ready_d;
   logic out_valid_q, out_valid_d;
   logic we;
   logic [11:0] wa;
   logic [7:0] wd;
   logic re;
   logic [7:0] rdata;
   logic [15:0] olen;
   logic [4:0] end_b;

   assign olen = {4'h0, wp_q - ictf_pkg::FIRST_INNER};
   assign end_b = 5'(field_vlen(f_q, hdr_q) + 16'h0003);

   ictf_ram u_ram (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(we),
      .wr_addr_i(wa),
      .wr_data_i(wd),
      .rd_en_i(re),
      .rd_addr_i(rp_q),
      .rd_data_o(rdata)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      state_d = state_q;
      hdr_d = hdr_q;
      out_d = out_q;
      wp_d = wp_q;
      rp_d = rp_q;
      blen_addr_d = blen_addr_q;
      blen_d = blen_q;
      f_d = f_q;
      b_d = b_q;
      pc_d = pc_q;
      meta_ready_d = meta_ready_q;
      in_ready_d = in_ready_q;
      out_valid_d = out_valid_q;
      we = 1'b0;
      wa = wp_q;
      wd = 8'h00;
      re = 1'b0;
      unique case (state_q)
         ictf_pkg::ST_IDLE: begin
            if (meta_valid_i && meta_ready_q) begin
               hdr_d = meta_i;
               meta_ready_d = 1'b0;
               f_d = ictf_pkg::F_HWRAP;
               b_d = 5'h00;
               state_d = ictf_pkg::ST_HDR;
            end
         end
         ictf_pkg::ST_HDR: begin
            // absent optional fields cost one idle cycle each
            if (!field_present(f_q, hdr_q)) begin
               f_d = f_q + 4'h1;
            end else begin
               we = 1'b1;
               wd = field_byte(f_q, b_q, hdr_q);
               wp_d = wp_q + 12'h001;
               b_d = b_q + 5'h01;
               if (f_q == ictf_pkg::F_BWRAP && b_q == 5'h02) begin
                  blen_addr_d = wp_q;
               end
               if (b_q == end_b) begin
                  b_d = 5'h00;
                  f_d = f_q + 4'h1;
                  if (f_q == ictf_pkg::F_BWRAP) begin
                     // header is always followed by its payload element
                     blen_d = 16'h0000;
                     in_ready_d = 1'b1;
                     state_d = ictf_pkg::ST_BODY;
                  end
               end
            end
         end
         ictf_pkg::ST_BODY: begin
            if (in_valid_i && in_ready_q) begin
               we = 1'b1;
               wd = in_i.data;
               wp_d = wp_q + 12'h001;
               blen_d = blen_q + 16'h0001;
               if (in_i.last) begin
                  in_ready_d = 1'b0;
                  pc_d = 3'h0;
                  state_d = ictf_pkg::ST_PATCH;
               end
            end
         end
         ictf_pkg::ST_PATCH: begin
            we = 1'b1;
            pc_d = pc_q + 3'h1;
            case (pc_q)
               3'h0: begin
                  wa = blen_addr_q;
                  wd = blen_q[7:0];
               end
               3'h1: begin
                  wa = blen_addr_q + 12'h001;
                  wd = blen_q[15:8];
                  if (!hdr_q.last_pkt) begin
                     // more pairs follow inside the same outer element
                     meta_ready_d = 1'b1;
                     state_d = ictf_pkg::ST_IDLE;
                  end
               end
               3'h2: begin
                  wa = ictf_pkg::OUTER_ADDR;
                  wd = ictf_pkg::TYPE_OUTER[7:0];
               end
               3'h3: begin
                  wa = ictf_pkg::OUTER_ADDR + 12'h001;
                  wd = ictf_pkg::TYPE_OUTER[15:8];
               end
               3'h4: begin
                  wa = ictf_pkg::OUTER_ADDR + 12'h002;
                  wd = olen[7:0];
               end
               default: begin
                  wa = ictf_pkg::OUTER_ADDR + 12'h003;
                  wd = olen[15:8];
                  rp_d = ictf_pkg::OUTER_ADDR;
                  state_d = ictf_pkg::ST_RD;
               end
            endcase
         end
         ictf_pkg::ST_RD: begin
            re = 1'b1;
            state_d = ictf_pkg::ST_LD;
         end
         ictf_pkg::ST_LD: begin
            // the first octet out is the outer type, no padding ahead
            out_d.data = rdata;
            out_d.first = (rp_q == ictf_pkg::OUTER_ADDR);
            out_d.last = (rp_q == wp_q - 12'h001);
            out_valid_d = 1'b1;
            state_d = ictf_pkg::ST_WAIT;
         end
         ictf_pkg::ST_WAIT: begin
            if (out_ready_i) begin
               out_valid_d = 1'b0;
               rp_d = rp_q + 12'h001;
               if (out_q.last) begin
                  wp_d = ictf_pkg::FIRST_INNER;
                  meta_ready_d = 1'b1;
                  state_d = ictf_pkg::ST_IDLE;
               end else begin
                  state_d = ictf_pkg::ST_RD;
               end
            end
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ictf_pkg::ST_IDLE;
         hdr_q <= '0;
         out_q <= '0;
         wp_q <= ictf_pkg::FIRST_INNER;
         rp_q <= ictf_pkg::OUTER_ADDR;
         blen_addr_q <= 12'h000;
         blen_q <= 16'h0000;
         f_q <= ictf_pkg::F_HWRAP;
         b_q <= 5'h00;
         pc_q <= 3'h0;
         meta_ready_q <= 1'b1;
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hdr_q <= hdr_d;
         out_q <= out_d;
         wp_q <= wp_d;
         rp_q <= rp_d;
         blen_addr_q <= blen_addr_d;
         blen_q <= blen_d;
         f_q <= f_d;
         b_q <= b_d;
         pc_q <= pc_d;
         meta_ready_q <= meta_ready_d;
         in_ready_q <= in_ready_d;
         out_valid_q <= out_valid_d;
      end
   end

   assign meta_ready_o = meta_ready_q;
   assign in_ready_o = in_ready_q;
   assign out_valid_o = out_valid_q;
   assign out_o = out_q;

   // vendor extension is never generated; only receivers must tolerate it

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_outer_first_type: assert property (
      out_valid_q && out_q.first |-> out_q.data == ictf_pkg::TYPE_OUTER[7:0])
      else $error("first output octet is not the outer type");
   a_type_high_zero: assert property (
      state_q == ictf_pkg::ST_HDR && we && b_q == 5'h01 |-> wd == 8'h00)
      else $error("type high octet not zero");
   a_hdr_wrap_type: assert property (
      state_q == ictf_pkg::ST_HDR && f_q == ictf_pkg::F_HWRAP && b_q == 5'h00
      |-> we && wd == ictf_pkg::TYPE_HDR[7:0])
      else $error("header element type wrong");
   a_body_after_hdr: assert property (
      state_q == ictf_pkg::ST_HDR && f_q == ictf_pkg::F_BWRAP && b_q == 5'h03
      |-> wd == 8'h00 ##1 state_q == ictf_pkg::ST_BODY && in_ready_q)
      else $error("payload element did not follow header");
   a_body_len_patch: assert property (
      state_q == ictf_pkg::ST_PATCH && pc_q == 3'h0
      |-> wa == blen_addr_q && wd == blen_q[7:0] ##1 wd == blen_q[15:8])
      else $error("payload length patch wrong");
   a_dir_value: assert property (
      state_q == ictf_pkg::ST_HDR && f_q == ictf_pkg::F_DIR && b_q == 5'h04 && hdr_q.has_dir
      |-> wd == {7'h00, hdr_q.dir})
      else $error("direction value wrong");
   a_corr_size: assert property (
      state_q == ictf_pkg::ST_HDR && f_q == ictf_pkg::F_CORR && b_q == 5'h02
      |-> wd == (hdr_q.corr_long ? ictf_pkg::CORR_LONG[7:0] : ictf_pkg::CORR_SHORT[7:0]))
      else $error("correlation length wrong");
   a_outer_len: assert property (
      state_q == ictf_pkg::ST_PATCH && pc_q == 3'h4 |-> wd == 8'(wp_q - ictf_pkg::FIRST_INNER))
      else $error("outer length wrong");
   a_out_hold: assert property (
      out_valid_q && !out_ready_i |=> out_valid_q && $stable(out_q))
      else $error("output changed while stalled");

endmodule

`default_nettype wire

// >>> pkg/ictf_pkg.sv
// Purpose: shared constants and carriers of the intercepted content framer
// Assumes: one system clock, byte-wide streams
// Notes:   all type codes are below 256, so every type high octet is zero

package ictf_pkg;

   // ************************************************************
   // memory and addressing
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam int MEM_DEPTH = 4096;
   localparam logic [11:0] OUTER_ADDR = 12'h000;
   localparam logic [11:0] FIRST_INNER = 12'h004;
   localparam logic [11:0] LAST_ADDR = 12'hfff;

   // ************************************************************
   // element type codes
   // ************************************************************
   localparam logic [15:0] TYPE_OUTER = 16'h00fb;
   localparam logic [15:0] TYPE_HDR = 16'h00fc;
   localparam logic [15:0] TYPE_BODY = 16'h00fd;
   localparam logic [15:0] TYPE_VER = 16'h0082;
   localparam logic [15:0] TYPE_KIND = 16'h0085;
   localparam logic [15:0] TYPE_TIME = 16'h0086;
   localparam logic [15:0] TYPE_DIR = 16'h0089;
   localparam logic [15:0] TYPE_SEQ = 16'h008d;
   localparam logic [15:0] TYPE_CORR = 16'h0090;
   localparam logic [15:0] TYPE_INTERCEPT_IDENTIFIER_FIELD = 16'h00fe;
   localparam logic [15:0] TYPE_EXT = 16'h00ff;

   // ************************************************************
   // field sizes and values
   // ************************************************************
   localparam logic [15:0] TL_BYTES = 16'h0004;
   localparam logic [15:0] VER_LEN = 16'h0002;
   localparam logic [15:0] KIND_LEN = 16'h0001;
   localparam logic [15:0] TIME_LEN = 16'h0004;
   localparam logic [15:0] DIR_LEN = 16'h0001;
   localparam logic [15:0] SEQ_LEN = 16'h0004;
   localparam logic [15:0] CORR_SHORT = 16'h0008;
   localparam logic [15:0] CORR_LONG = 16'h0014;
   localparam logic [4:0] INTERCEPT_IDENTIFIER_FIELD_MAX = 5'h19;
   localparam logic [7:0] KIND_OTHER = 8'hff;
   localparam logic DIR_TO_TARGET = 1'b0;
   localparam logic DIR_FROM_TARGET = 1'b1;

   // ************************************************************
   // header field walk order
   // ************************************************************
   localparam logic [3:0] F_HWRAP = 4'h0;
   localparam logic [3:0] F_VER = 4'h1;
   localparam logic [3:0] F_KIND = 4'h2;
   localparam logic [3:0] F_TIME = 4'h3;
   localparam logic [3:0] F_DIR = 4'h4;
   localparam logic [3:0] F_SEQ = 4'h5;
   localparam logic [3:0] F_CORR = 4'h6;
   localparam logic [3:0] F_INTERCEPT_IDENTIFIER_FIELD = 4'h7;
   localparam logic [3:0] F_BWRAP = 4'h8;
   localparam logic [2:0] PATCH_LAST = 3'h5;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [15:0] version;
      logic [7:0] kind;
      logic has_time;
      logic [31:0] stamp;
      logic has_dir;
      logic dir;
      logic has_seq;
      logic [31:0] seq;
      logic corr_long;
      logic [159:0] corr;
      logic [4:0] intercept_identifier_field_len;
      logic [199:0] intercept_identifier_field;
      logic last_pkt;
   } ictf_hdr_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } ictf_byte_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic first;
   } ictf_out_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_HDR = 7'h02,
      ST_BODY = 7'h04,
      ST_PATCH = 7'h08,
      ST_RD = 7'h10,
      ST_LD = 7'h20,
      ST_WAIT = 7'h40
   } ictf_state_t;

endpackage

// >>> rtl/ictf_ram.sv
// Purpose: message assembly memory, one write and one read port
// Assumes: read data valid one clock after rd_en_i
// Notes:   no reset on the array, only on the read register

`timescale 1ns/1ps
`default_nettype none

module ictf_ram (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic wr_en_i,
   input wire logic [11:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [11:0] rd_addr_i,
   output logic [7:0] rd_data_o
);

   logic [7:0] mem [0:ictf_pkg::MEM_DEPTH-1];
   logic [7:0] rd_data_q;

   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_q <= 8'h00;
      end else if (rd_en_i) begin
         rd_data_q <= mem[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_q;

endmodule

`default_nettype wire

// >>> tb/ictf_sink.sv
// Purpose: carrier-side sink that takes framed octets and walks the elements
// Assumes: one message collected at a time, bench clears it between messages
// Notes:   slow mode drops ready every other cycle, like a congested link

`timescale 1ns/1ps
`default_nettype none

module ictf_sink (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic val_i,
   input wire ictf_pkg::ictf_out_t oct_i,
   output logic ready_o
);
   // ****************
   // capture
   // ****************
   logic [7:0] got[$];
   int flag_err = 0;
   int last_at = -1;
   logic tick_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_q <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         tick_q <= ~tick_q;
         ready_o <= ~slow_i | tick_q;
         if (val_i && ready_o) begin
            // octets kept in arrival order, least significant first
            if (oct_i.first !== (got.size() == 0)) flag_err++;
            if (oct_i.last === 1'b1) last_at = got.size();
            got.push_back(oct_i.data);
         end
      end
   end

   // ****************
   // element walk
   // ****************
   // any type is stepped over by its length, never by its code
   function automatic int count_inner();
      int idx;
      int n;
      idx = 4;
      n = 0;
      while (idx + 3 < got.size() && n < 1000) begin
         idx = idx + 4 + {got[idx + 3], got[idx + 2]};
         n++;
      end
      return n;
   endfunction
endmodule

`default_nettype wire

// >>> tb/ictf_framer_tb.sv
// Purpose: self-checking bench of the content framer
// Assumes: sink model on the output side
// Notes:   expected octets built from the element layout, not from the design

`timescale 1ns/1ps
`default_nettype none

module ictf_framer_tb;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic meta_valid_i = 1'b0;
   ictf_pkg::ictf_hdr_t meta_i = '0;
   logic in_valid_i = 1'b0;
   ictf_pkg::ictf_byte_t in_i = '0;
   logic slow = 1'b0;
   logic meta_ready_o;
   logic in_ready_o;
   logic out_valid_o;
   logic out_ready_i;
   ictf_pkg::ictf_out_t out_o;
   logic [7:0] body[$];
   logic [7:0] exp[$];
   int n_fail = 0;
   int total_checks = 0;

   always #10 sys_clk_i = ~sys_clk_i;

   ictf_framer DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .meta_valid_i(meta_valid_i),
      .meta_i(meta_i), .meta_ready_o(meta_ready_o), .in_valid_i(in_valid_i), .in_i(in_i),
      .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_o(out_o),
      .out_ready_i(out_ready_i));
   ictf_sink SINK (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow), .val_i(out_valid_o),
      .oct_i(out_o), .ready_o(out_ready_i));

   // ****************
   // helpers
   // ****************
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      total_checks++;
      if (got !== want) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic tl(input logic [15:0] t, input logic [15:0] l);
      body.push_back(t[7:0]);
      body.push_back(t[15:8]);
      body.push_back(l[7:0]);
      body.push_back(l[15:8]);
   endtask

   task automatic send(input ictf_pkg::ictf_hdr_t h, input int n, input logic [7:0] base);
      int i;
      int k;
      int cl;
      int ll;
      cl = h.corr_long ? 20 : 8;
      // identifiers over the limit are left out of the header
      ll = (h.intercept_identifier_field_len <= 25) ? int'(h.intercept_identifier_field_len) : 0;
      tl(16'h00fc, 16'h000b + 16'(4 + cl) + (h.has_time ? 16'h0008 : 16'h0000)
         + (h.has_dir ? 16'h0005 : 16'h0000) + (h.has_seq ? 16'h0008 : 16'h0000)
         + (ll != 0 ? 16'(4 + ll) : 16'h0000));
      tl(16'h0082, 16'd2);
      body.push_back(h.version[7:0]);
      body.push_back(h.version[15:8]);
      tl(16'h0085, 16'd1);
      body.push_back(h.kind);
      if (h.has_time) tl(16'h0086, 16'd4);
      for (i = 0; i < 4 && h.has_time; i++) body.push_back(h.stamp[8 * i +: 8]);
      if (h.has_dir) tl(16'h0089, 16'd1);
      if (h.has_dir) body.push_back({7'h00, h.dir});
      if (h.has_seq) tl(16'h008d, 16'd4);
      for (i = 0; i < 4 && h.has_seq; i++) body.push_back(h.seq[8 * i +: 8]);
      tl(16'h0090, 16'(cl));
      for (i = 0; i < cl; i++) body.push_back(h.corr[8 * i +: 8]);
      if (ll != 0) tl(16'h00fe, 16'(ll));
      for (i = 0; i < ll; i++) body.push_back(h.intercept_identifier_field[8 * i +: 8]);
      tl(16'h00fd, 16'(n));
      for (i = 0; i < n; i++) body.push_back(base + 8'(i));
      meta_i <= h;
      meta_valid_i <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (meta_ready_o !== 1'b1 && k < 2000);
      meta_valid_i <= 1'b0;
      in_valid_i <= 1'b1;
      in_i <= {base, n == 1};
      i = 0;
      while (i < n && k < 4000) begin
         @(posedge sys_clk_i);
         k++;
         if (in_ready_o === 1'b1) begin
            i++;
            in_i <= {base + 8'(i), i == n - 1};
         end
      end
      in_valid_i <= 1'b0;
      check(k < 4000, 1);
   endtask

   // collects the message and compares it whole against the expected octets
   task automatic finish_msg(input int pairs);
      int i;
      exp = {8'hfb, 8'h00, 8'(body.size()), 8'(body.size() >> 8), body};
      i = 0;
      while (SINK.last_at < 0 && i < 5000) begin
         @(posedge sys_clk_i);
         i++;
      end
      check(SINK.got.size(), exp.size());
      for (i = 0; i < exp.size() && i < SINK.got.size(); i++)
         check(SINK.got[i], exp[i]);
      check(SINK.flag_err, 0);
      check(SINK.last_at, exp.size() - 1);
      check(SINK.count_inner(), 2 * pairs);
      repeat (2) @(posedge sys_clk_i);
      check(meta_ready_o, 1);
      body.delete();
      SINK.got.delete();
      SINK.last_at = -1;
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      check({meta_ready_o, in_ready_o, out_valid_o}, 3'h4);
   endtask

   // reset in mid-stream drops the message; the next one must come out whole
   task automatic t_midreset();
      ictf_pkg::ictf_hdr_t h;
      h = '0;
      h.kind = 8'h21;
      h.last_pkt = 1'b1;
      send(h, 2, 8'h40);
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b1;
      @(posedge sys_clk_i);
      check({meta_ready_o, in_ready_o, out_valid_o}, 3'h4);
      rst_i <= 1'b0;
      body.delete();
      SINK.got.delete();
      SINK.last_at = -1;
      @(posedge sys_clk_i);
      h.kind = 8'h22;
      send(h, 2, 8'h50);
      finish_msg(1);
   endtask

   // every optional field, other-protocol kind, long correlation, longest identifier
   task automatic t_full();
      ictf_pkg::ictf_hdr_t h;
      h = '0;
      h.version = 16'h1234;
      h.kind = 8'hff;
      h.has_time = 1'b1;
      h.stamp = 32'h5e0f1a2b;
      h.has_dir = 1'b1;
      h.dir = 1'b1;
      h.has_seq = 1'b1;
      h.seq = 32'h89abcdef;
      h.corr_long = 1'b1;
      h.corr = {20{8'h3c}} ^ 160'h0102030405060708090a0b0c0d0e0f1011121314;
      h.intercept_identifier_field_len = 5'h19;
      h.intercept_identifier_field = {25{8'h41}} + 200'h0102030405;
      h.last_pkt = 1'b1;
      send(h, 3, 8'h10);
      finish_msg(1);
   endtask

   // three packets, direction and 13-octet identifier on the second only, payloads of 1, 5 and 6 octets, stalling sink
   task automatic t_multi();
      ictf_pkg::ictf_hdr_t h;
      int p;
      slow <= 1'b1;
      for (p = 0; p < 3; p++) begin
         h = '0;
         h.version = 16'h0002;
         h.kind = 8'(p + 1);
         h.has_dir = (p == 1);
         h.dir = 1'b0;
         h.intercept_identifier_field_len = 5'(13 * p);
         h.intercept_identifier_field = {25{8'h5a}};
         h.corr = 160'(64'hfedcba9876543210 + p);
         h.last_pkt = (p == 2);
         send(h, p == 0 ? 1 : 4 + p, 8'(8'h80 + 16 * p));
      end
      finish_msg(3);
      slow <= 1'b0;
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      t_reset();
      t_full();
      t_midreset();
      t_multi();
      summarize();
   end
endmodule

`default_nettype wire
